// file: hdl/scc_control_regs.sv
/*
  Control and calibration register bank of a wideband synthesizer.
  Registers are reached over a 4-wire serial port on pins.
  Assumes clock is the reference input; pins are asynchronous.
*/
`include "scc_regs.svh"
`default_nettype none

module scc_control_regs #(
  parameter int unsigned AMP_W = 9,
  parameter int unsigned CAP_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              sclk_pin,
  input  wire logic              cs_n_pin,
  input  wire logic              sdi_pin,
  input  wire logic              lock_status_pin,
  input  wire logic [AMP_W-1:0]  oscillator_amplitude_code,
  input  wire logic [CAP_W-1:0]  cap_bank_code,
  input  wire logic [AMP_W-1:0]  amp_cal_result,
  input  wire logic [CAP_W-1:0]  cap_cal_result,
  output logic                   status_output_pin,
  output logic                   lock_detect_enable,
  output logic [1:0]             freq_cal_high_compare_adjust,
  output logic [1:0]             freq_cal_low_compare_adjust,
  output logic                   power_down,
  output logic                   cal_clock_tick,
  output scc_pkg::scc_cal_t      cal_status,
  output logic [AMP_W-1:0]       amp_code_out,
  output logic [CAP_W-1:0]       cap_code_out
);
  import scc_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pin_vec;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  assign pin_vec = {lock_status_pin, sdi_pin, cs_n_pin, sclk_pin};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clock) begin
        if (rst) begin
          sync1_reg[i] <= (i == 1) ? 1'b1 : 1'b0;
          sync2_reg[i] <= (i == 1) ? 1'b1 : 1'b0;
        end else begin
          sync1_reg[i] <= pin_vec[i];
          sync2_reg[i] <= sync1_reg[i];
        end
      end
    end
  endgenerate

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic lock_s;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic sclk_rise;
  logic cs_rise;

  assign sclk_s    = sync2_reg[0];
  assign cs_n_s    = sync2_reg[1];
  assign sdi_s     = sync2_reg[2];
  assign lock_s    = sync2_reg[3];
  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign cs_rise   = cs_n_s & ~cs_prev_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_n_s;
    end
  end

  // ****************************************
  // Serial frame receiver
  // ****************************************
  logic [23:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  scc_frame_t  frame;
  logic        wr_en;

  always_ff @(posedge clock) begin
    if (rst || cs_n_s) begin
      bit_cnt_reg <= 5'd0;
    end else if (sclk_rise && bit_cnt_reg < `SCC_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 5'd1; // R18
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_reg <= 24'h000000;
    end else if (!cs_n_s && sclk_rise && bit_cnt_reg < `SCC_FRAME_BITS) begin
      shift_reg <= {shift_reg[22:0], sdi_s}; // R18
    end
  end

  assign frame = scc_frame_t'(shift_reg);
  assign wr_en = cs_rise && bit_cnt_reg == `SCC_FRAME_BITS && !frame.rd; // R18

  // ****************************************
  // Register bank
  // ****************************************
  logic [15:0] main_reg;
  logic [15:0] clkcfg_reg;
  logic [15:0] rsv_a_reg;
  logic [15:0] ampt_reg;
  logic [15:0] rsv_b_reg;
  logic [15:0] ovr_reg;
  logic        soft_rst_reg;
  logic        cal_start_reg;
  logic        main_wr;

  assign main_wr = wr_en && frame.addr == `SCC_ADDR_MAIN;

  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg) begin
      main_reg   <= `SCC_MAIN_RST; // R17
      clkcfg_reg <= `SCC_CLKCFG_RST;
      rsv_a_reg  <= `SCC_RSV_A_RST;
      ampt_reg   <= `SCC_AMPT_RST;
      rsv_b_reg  <= `SCC_RSV_B_RST;
      ovr_reg    <= `SCC_OVR_RST;
    end else if (wr_en) begin
      case (frame.addr)
        `SCC_ADDR_MAIN: begin
          main_reg <= frame.data & ~(16'h0001 << `SCC_SRST_BIT); // R7
        end
        `SCC_ADDR_CLKCFG: clkcfg_reg <= frame.data;
        `SCC_ADDR_RSV_A:  rsv_a_reg  <= frame.data;
        `SCC_ADDR_AMPT:   ampt_reg   <= frame.data;
        `SCC_ADDR_RSV_B:  rsv_b_reg  <= frame.data;
        `SCC_ADDR_OVR:    ovr_reg    <= frame.data;
        default: ;
      endcase
    end
  end

  // Soft reset request, one cycle after the frame
  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= main_wr && frame.data[`SCC_SRST_BIT]; // R7
    end
  end

  // Calibration trigger on a written 1
  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg) begin
      cal_start_reg <= 1'b0;
    end else begin
      cal_start_reg <= main_wr && frame.data[`SCC_FCAL_BIT] && !frame.data[`SCC_SRST_BIT]; // R5
    end
  end

  logic amp_ovr;
  logic cap_ovr;
  logic amplitude_cal_enable;
  logic [7:0] cmp_dly;
  logic [2:0] div_exp;

  assign amp_ovr = ovr_reg[`SCC_AOVR_BIT];
  assign cap_ovr = ovr_reg[`SCC_COVR_BIT];
  assign amplitude_cal_enable = main_reg[`SCC_ACAL_BIT];
  assign cmp_dly = ampt_reg[`SCC_DLY_HI:`SCC_DLY_LO];
  assign div_exp = clkcfg_reg[`SCC_DIV_HI:0];

  // Field outputs straight from the bank
  assign lock_detect_enable           = main_reg[`SCC_LOCK_DETECT_ENABLE_BIT]; // R1
  assign freq_cal_high_compare_adjust = main_reg[`SCC_HADJ_HI:`SCC_HADJ_LO]; // R2
  assign freq_cal_low_compare_adjust  = main_reg[`SCC_LADJ_HI:`SCC_LADJ_LO]; // R3
  assign power_down                   = main_reg[`SCC_PD_BIT]; // R8

  // ****************************************
  // Readback
  // ****************************************
  function automatic logic [15:0] rd_mux(input logic [6:0] a);
    logic [15:0] d;
    d = 16'h0000;
    case (a)
      `SCC_ADDR_MAIN:   d = main_reg;
      `SCC_ADDR_CLKCFG: d = clkcfg_reg;
      `SCC_ADDR_RSV_A:  d = rsv_a_reg;
      `SCC_ADDR_AMPT:   d = ampt_reg;
      `SCC_ADDR_RSV_B:  d = rsv_b_reg;
      `SCC_ADDR_OVR:    d = ovr_reg;
      default:          d = 16'h0000;
    endcase
    return d;
  endfunction : rd_mux

  logic [15:0] rd_shift_reg;

  always_ff @(posedge clock) begin
    if (rst || cs_n_s) begin
      rd_shift_reg <= 16'h0000;
    end else if (sclk_rise && bit_cnt_reg == `SCC_ADDR_DONE) begin
      rd_shift_reg <= shift_reg[6] ? rd_mux({shift_reg[5:0], sdi_s}) : 16'h0000; // R18
    end else if (sclk_rise && bit_cnt_reg > `SCC_ADDR_DONE) begin
      rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
    end
  end

  // Status pin source
  always_ff @(posedge clock) begin
    if (rst) begin
      status_output_pin <= 1'b0;
    end else if (main_reg[`SCC_SEL_BIT]) begin
      status_output_pin <= lock_s & main_reg[`SCC_LOCK_DETECT_ENABLE_BIT]; // R6
    end else begin
      status_output_pin <= rd_shift_reg[15]; // R6
    end
  end

  // ****************************************
  // Calibration clock divider
  // ****************************************
  logic [6:0] div_cnt_reg;
  logic [6:0] div_lim;

  assign div_lim = 7'((8'h01 << div_exp) - 8'h01);

  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg || power_down) begin
      div_cnt_reg    <= 7'h00;
      cal_clock_tick <= 1'b0;
    end else begin
      cal_clock_tick <= div_cnt_reg >= div_lim; // R9
      div_cnt_reg    <= (div_cnt_reg >= div_lim) ? 7'h00 : div_cnt_reg + 7'h01;
    end
  end

  // ****************************************
  // Calibration sequencer
  // ****************************************
  scc_cal_state_t state_reg;
  logic [7:0]     wait_reg;
  logic           amp_done;
  logic           freq_done;

  assign amp_done  = cal_clock_tick && (9'(wait_reg) + 9'h001 >= {1'b0, cmp_dly}); // R11
  assign freq_done = cal_clock_tick && (wait_reg + 8'h01 >= `SCC_FCAL_TICKS);

  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg || power_down) begin
      state_reg <= SCC_IDLE; // R8
      wait_reg  <= 8'h00;
    end else begin
      unique case (state_reg)
        SCC_IDLE: begin
          wait_reg <= 8'h00;
          if (cal_start_reg && amplitude_cal_enable && !amp_ovr) begin
            state_reg <= SCC_AMP; // R4
          end else if (cal_start_reg && !cap_ovr) begin
            state_reg <= SCC_FREQ; // R12
          end
        end
        SCC_AMP: begin
          if (amp_done) begin
            wait_reg  <= 8'h00;
            state_reg <= cap_ovr ? SCC_IDLE : SCC_FREQ; // R14
          end else if (cal_clock_tick) begin
            wait_reg <= wait_reg + 8'h01;
          end
        end
        SCC_FREQ: begin
          if (freq_done) begin
            wait_reg  <= 8'h00;
            state_reg <= SCC_IDLE;
          end else if (cal_clock_tick) begin
            wait_reg <= wait_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // Calibrated codes, captured at phase end
  logic [AMP_W-1:0] amp_cal_reg;
  logic [CAP_W-1:0] cap_cal_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      amp_cal_reg <= '0;
      cap_cal_reg <= '0;
    end else begin
      if (state_reg == SCC_AMP && amp_done) begin
        amp_cal_reg <= amp_cal_result; // R4
      end
      if (state_reg == SCC_FREQ && freq_done) begin
        cap_cal_reg <= cap_cal_result;
      end
    end
  end

  // Codes to the oscillator
  always_ff @(posedge clock) begin
    if (rst) begin
      amp_code_out <= '0;
      cap_code_out <= '0;
      cal_status   <= '0;
    end else begin
      amp_code_out <= amp_ovr ? oscillator_amplitude_code : amp_cal_reg; // R12
      cap_code_out <= cap_ovr ? cap_bank_code : cap_cal_reg; // R14
      cal_status   <= '{busy:       state_reg != SCC_IDLE,
                        amp_phase:  state_reg == SCC_AMP,
                        freq_phase: state_reg == SCC_FREQ};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  reset_defaults_a: assert property (disable iff (1'b0) rst |=> main_reg == `SCC_MAIN_RST && ampt_reg == `SCC_AMPT_RST) // R17
    else $error("bank not at defaults after reset");

  soft_reset_clear_a: assert property (main_wr && frame.data[`SCC_SRST_BIT] |=> // R7
      soft_rst_reg ##1 (main_reg == `SCC_MAIN_RST && !main_reg[`SCC_SRST_BIT]))
    else $error("soft reset did not restore bank");

  frame_length_a: assert property (cs_rise && bit_cnt_reg != `SCC_FRAME_BITS |=> $stable(main_reg)) // R18
    else $error("short frame changed a register");

  fcal_start_a: assert property (cal_start_reg && state_reg == SCC_IDLE && !power_down && !cap_ovr |=> // R5
      state_reg != SCC_IDLE)
    else $error("calibration did not start");

  amp_skip_a: assert property (state_reg == SCC_IDLE && amp_ovr |=> state_reg != SCC_AMP) // R12
    else $error("amplitude calibration ran under override");

  cap_skip_a: assert property (state_reg != SCC_FREQ ##1 state_reg == SCC_FREQ |-> !$past(cap_ovr)) // R14
    else $error("frequency calibration ran under override");

  amp_wait_a: assert property (state_reg == SCC_AMP && cal_clock_tick && !power_down && !soft_rst_reg && // R11
      9'(wait_reg) + 9'h001 < {1'b0, cmp_dly} |=> state_reg == SCC_AMP && wait_reg == $past(wait_reg) + 8'h01)
    else $error("amplitude wait ended early");

  cal_tick_a: assert property (!power_down && !soft_rst_reg && div_cnt_reg == div_lim |=> cal_clock_tick) // R9
    else $error("calibration tick missing");

  status_lock_a: assert property (main_reg[`SCC_SEL_BIT] |=> // R6
      status_output_pin == ($past(lock_s) & $past(lock_detect_enable)))
    else $error("status pin not showing lock");

  powerdown_idle_a: assert property (power_down |=> state_reg == SCC_IDLE && !cal_clock_tick) // R8
    else $error("activity while powered down");

endmodule : scc_control_regs

`default_nettype wire

// file: include/scc_regs.svh
/*
  Constants of the synthesizer control and calibration register bank:
  register addresses, field positions, reset values, timing counts.
  Assumes inclusion by the bank module and by its bench.
*/
// Operation
// R1 - Lock-detect enable bit 13 of main control gates lock detection, default 1.
// R2 - High-compare adjust bits 8:7: 3 >200, 2 >150, 1 >100 MHz, 0 unused.
// R3 - Low-compare adjust bits 6:5: 3 <5, 2 <10, 1 <20 MHz, 0 unused.
// R4 - Amplitude calibration enable bit 4 lets calibration set oscillator amplitude.
// R5 - Writing 1 to frequency calibration enable bit 3 starts calibration.
// R6 - Status select bit 2: 1 shows lock status, 0 shows readback data.
// R7 - Writing 1 to soft reset bit 1 resets device; bit reads back 0.
// R8 - Power-down bit 0 powers whole device down when 1, default 0; the bank only holds the calibration divider and sequencer idle.
// R9 - Calibration clock is reference divided by two to the exponent, default 3.
// R10 - Host picks exponent keeping calibration clock just under 200 MHz.
// R11 - Compare delay bits 15:8 set amplitude calibration wait, default 25.
// R12 - Amplitude override bit 13 skips amplitude calibration, uses programmed code.
// R13 - Host keeps programmed amplitude code between 250 and 450.
// R14 - Capacitor bank override bit 10 skips frequency calibration, uses programmed code.
// R15 - Host sets core-select force, then writes core number 1 to 7.
// R16 - Host writes unnamed fields and reserved registers with map defaults.
// R17 - After reset calibration enables and status select read 1, soft reset 0.
// R18 - Each access is 24 bits: read flag, 7-bit address, 16 data, MSB first.
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// ****************************************
// Addresses
// ****************************************
`define SCC_ADDR_MAIN     7'h00
`define SCC_ADDR_CLKCFG   7'h01
`define SCC_ADDR_RSV_A    7'h02
`define SCC_ADDR_AMPT     7'h04
`define SCC_ADDR_RSV_B    7'h07
`define SCC_ADDR_OVR      7'h08

// ****************************************
// Field positions
// ****************************************
`define SCC_LOCK_DETECT_ENABLE_BIT     13
`define SCC_HADJ_HI       8
`define SCC_HADJ_LO       7
`define SCC_LADJ_HI       6
`define SCC_LADJ_LO       5
`define SCC_ACAL_BIT      4
`define SCC_FCAL_BIT      3
`define SCC_SEL_BIT       2
`define SCC_SRST_BIT      1
`define SCC_PD_BIT        0
`define SCC_DIV_HI        2
`define SCC_DLY_HI        15
`define SCC_DLY_LO        8
`define SCC_AOVR_BIT      13
`define SCC_COVR_BIT      10

// ****************************************
// Reset values and timing
// ****************************************
`define SCC_MAIN_RST      16'h201c
`define SCC_CLKCFG_RST    16'h0003
`define SCC_RSV_A_RST     16'h0000
`define SCC_AMPT_RST      16'h1900
`define SCC_RSV_B_RST     16'h0000
`define SCC_OVR_RST       16'h0000
`define SCC_FRAME_BITS    5'd24
`define SCC_ADDR_DONE     5'd7
`define SCC_FCAL_TICKS    8'h10

`endif

// file: include/scc_pkg.sv
/*
  Types of the synthesizer control register bank.
  Assumes scc_regs.svh for numeric constants.
*/
`default_nettype none

package scc_pkg;

  // Serial frame, first bit in the top position
  typedef struct packed {
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] data;
  } scc_frame_t;

  // Calibration sequencer states, one bit changing from IDLE to AMP and from AMP to FREQ
  typedef enum logic [1:0] {
    SCC_IDLE = 2'h0,
    SCC_AMP  = 2'h1,
    SCC_FREQ = 2'h3
  } scc_cal_state_t;

  // Calibration progress seen by the analog side
  typedef struct packed {
    logic busy;
    logic amp_phase;
    logic freq_phase;
  } scc_cal_t;

endpackage : scc_pkg

`default_nettype wire

// file: verif/scc_host_model.sv
/*
  Host controller model driving the 4-wire serial port of the bank.
  Assumes the bank's clock; the bench calls xfer through the instance.
*/
`default_nettype none

module scc_host_model (
  input  wire logic clock,
  input  wire logic status_output_pin,
  output var logic  sclk_pin,
  output var logic  cs_n_pin,
  output var logic  sdi_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import scc_pkg::*;

  // ****************************************
  // Serial frames
  // ****************************************
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    sdi_pin  = 1'b0;
  end

  // Nbits sent MSB first, readback taken at the sclk rise of each data bit (bit 8 on)
  task automatic xfer(input scc_frame_t f, input int nbits, input int half, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clock) cs_n_pin <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi_pin <= f[23-i];
      repeat (half) @(posedge clock);
      sclk_pin <= 1'b1;
      if (i >= 8) begin
        rd[23-i] = status_output_pin;
      end
      repeat (half) @(posedge clock);
      sclk_pin <= 1'b0;
    end
    repeat (half) @(posedge clock);
    cs_n_pin <= 1'b1;
    sdi_pin  <= ~sdi_pin;
    repeat (6) @(posedge clock);
  endtask : xfer

endmodule : scc_host_model

`default_nettype wire

// file: verif/scc_control_regs_tb.sv
/*
  Self-checking bench of the synthesizer control register bank.
  Assumes scc_host_model drives the serial pins.
*/
`include "scc_regs.svh"
`default_nettype none

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end

module scc_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scc_pkg::*;

  logic       clock, rst, sclk_pin, cs_n_pin, sdi_pin, lock_status_pin;
  logic [8:0] oscillator_amplitude_code, amp_cal_result, amp_code_out;
  logic [7:0] cap_bank_code, cap_cal_result, cap_code_out;
  logic       status_output_pin, lock_detect_enable, power_down, cal_clock_tick;
  logic [1:0] freq_cal_high_compare_adjust, freq_cal_low_compare_adjust;
  scc_cal_t   cal_status;
  int         err_count, checks;
  logic [6:0]  adr [6] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h07, 7'h08};
  logic [15:0] dft [6] = '{16'h2010, 16'h0003, 16'h0000, 16'h1900, 16'h0000, 16'h0000};

  scc_control_regs i_dut (.clock, .rst, .sclk_pin, .cs_n_pin, .sdi_pin, .lock_status_pin,
    .oscillator_amplitude_code, .cap_bank_code, .amp_cal_result, .cap_cal_result,
    .status_output_pin, .lock_detect_enable, .freq_cal_high_compare_adjust,
    .freq_cal_low_compare_adjust, .power_down, .cal_clock_tick, .cal_status,
    .amp_code_out, .cap_code_out);

  scc_host_model i_host (.clock, .status_output_pin, .sclk_pin, .cs_n_pin, .sdi_pin);

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_host.xfer({1'b0, a, d}, 24, 4, x);
  endtask : wr

  task automatic rdr(input logic [6:0] a, output logic [15:0] d);
    i_host.xfer({1'b1, a, 16'h0000}, 24, 6, d);
  endtask : rdr

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic limit(input int n);
    if (n >= 300) begin
      err_count++;
      $display("BAD wait exp done got timeout");
      test_done();
    end
  endtask : limit

  // Clocks spent in amplitude and frequency phases of one run
  task automatic phase_len(output int na, output int nf);
    int n;
    n = 0;
    na = 0;
    nf = 0;
    while (cal_status.busy !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    limit(n);
    while (cal_status.amp_phase === 1'b1 && na < 300) begin
      cyc(1);
      na++;
    end
    limit(na);
    while (cal_status.freq_phase === 1'b1 && nf < 300) begin
      cyc(1);
      nf++;
    end
    limit(nf);
  endtask : phase_len

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [15:0] d;
    `CHK("lock_detect_enable", 1'b1, lock_detect_enable)
    `CHK("pd", 1'b0, power_down)
    `CHK("hadj", 2'h0, freq_cal_high_compare_adjust)
    `CHK("ladj", 2'h0, freq_cal_low_compare_adjust)
    `CHK("lock_pin", 1'b1, status_output_pin)
    lock_status_pin <= 1'b0;
    cyc(5);
    `CHK("unlock_pin", 1'b0, status_output_pin)
    wr(adr[0], dft[0]);
    for (int i = 0; i < 6; i++) begin
      rdr(adr[i], d);
      `CHK("default", dft[i], d)
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [15:0] d;
    for (int i = 1; i < 6; i++) begin
      wr(adr[i], 16'h5a00 | 16'(i));
      rdr(adr[i], d);
      `CHK("rw", 16'h5a00 | 16'(i), d)
      wr(adr[i], dft[i]);
    end
    wr(7'h03, 16'hffff);
    rdr(7'h03, d);
    `CHK("unmapped", 16'h0000, d)
    i_host.xfer({1'b0, adr[3], 16'h7700}, 23, 4, d);
    rdr(adr[3], d);
    `CHK("short_frame", 16'h1900, d)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_fields;
    for (int c = 0; c < 4; c++) begin
      wr(adr[0], {3'h1, 4'h0, c[1:0], ~c[1:0], 5'h10});
      `CHK("hadj", c[1:0], freq_cal_high_compare_adjust)
      `CHK("ladj", ~c[1:0], freq_cal_low_compare_adjust)
    end
    wr(adr[0], 16'h2011);
    `CHK("pd_on", 1'b1, power_down)
    lock_status_pin <= 1'b1;
    wr(adr[0], 16'h0014);
    `CHK("ld_off", 1'b0, lock_detect_enable)
    `CHK("pin_off", 1'b0, status_output_pin)
    wr(adr[0], 16'h2014);
    `CHK("pin_lock", 1'b1, status_output_pin)
    wr(adr[0], 16'h2010);
    `CHK("pd_off", 1'b0, power_down)
    $display("t_fields done");
  endtask : t_fields

  task automatic t_div;
    int n;
    for (int e = 1; e < 6; e += 2) begin
      wr(adr[1], {13'h0000, e[2:0]});
      n = 0;
      while (cal_clock_tick !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      limit(n);
      n = 0;
      cyc(1);
      while (cal_clock_tick !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      limit(n);
      `CHK("tick_gap", 1 << e, n + 1)
    end
    $display("t_div done");
  endtask : t_div

  task automatic t_cal;
    int na, nf, n;
    wr(adr[3], 16'h0400);
    wr(adr[1], 16'h0001);
    fork
      wr(adr[0], 16'h2018);
      phase_len(na, nf);
    join
    `CHK("amp_len", 1'b1, na >= 7 && na <= 9)
    `CHK("freq_len", 1'b1, nf >= 31 && nf <= 33)
    `CHK("amp_code", amp_cal_result, amp_code_out)
    `CHK("cap_code", cap_cal_result, cap_code_out)
    fork
      wr(adr[0], 16'h2008);
      phase_len(na, nf);
    join
    `CHK("no_amp", 0, na)
    n = 0;
    fork
      wr(adr[0], 16'h2010);
      repeat (250) begin
        cyc(1);
        if (cal_status.busy === 1'b1) n++;
      end
    join
    `CHK("no_cal", 0, n)
    $display("t_cal done");
  endtask : t_cal

  task automatic t_override;
    int na, nf;
    wr(adr[5], 16'h2000);
    amp_cal_result <= 9'h0f0;
    cap_cal_result <= 8'h3c;
    fork
      wr(adr[0], 16'h2018);
      phase_len(na, nf);
    join
    `CHK("aovr_len", 0, na)
    `CHK("aovr_amp", 9'h12c, amp_code_out)
    `CHK("aovr_cap", 8'h3c, cap_code_out)
    wr(adr[5], 16'h0400);
    fork
      wr(adr[0], 16'h2018);
      phase_len(na, nf);
    join
    `CHK("covr_len", 0, nf)
    `CHK("covr_cap", 8'h5a, cap_code_out)
    `CHK("covr_amp", 9'h0f0, amp_code_out)
    $display("t_override done");
  endtask : t_override

  task automatic t_softreset;
    logic [15:0] d;
    wr(adr[1], 16'h0005);
    wr(adr[3], 16'h0a00);
    wr(adr[0], 16'h2013);
    cyc(4);
    `CHK("srst_pd", 1'b0, power_down)
    `CHK("srst_pin", 1'b1, status_output_pin)
    wr(adr[0], 16'h2010);
    for (int i = 1; i < 6; i++) begin
      rdr(adr[i], d);
      `CHK("srst_reg", dft[i], d)
    end
    $display("t_softreset done");
  endtask : t_softreset

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    lock_status_pin = 1'b1;
    oscillator_amplitude_code = 9'h12c;
    cap_bank_code = 8'h5a;
    amp_cal_result = 9'h155;
    cap_cal_result = 8'ha3;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cyc(6);
    t_reset();
    t_regs();
    t_fields();
    t_div();
    t_cal();
    t_override();
    t_softreset();
    test_done();
  end

endmodule : scc_control_regs_tb

`default_nettype wire
